// ---- src/rlqm_pkg.sv ----
/*
 * Constants for the link quality monitor: register indices, field positions,
 * reset values, window lengths and the latency and power code tables.
 * Assumes nothing of its surroundings; imported by the monitor and the bench.
 */
package rlqm_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_INTERRUPT_FLAGS  = 8'h02;
	localparam logic [7:0] IDX_LINK_STATE       = 8'h03;
	localparam logic [7:0] IDX_LINK_QUALITY     = 8'h04;
	localparam logic [7:0] IDX_PERMANENT_LOSS   = 8'h05;
	localparam logic [7:0] IDX_LINK_ACTION_MODE = 8'h36;
	localparam logic [7:0] IDX_QUALITY_WARN_TH  = 8'h37;
	localparam logic [7:0] IDX_LOSS_ERROR_TH    = 8'h38;
	localparam logic [7:0] IDX_RX_OUTPUT_POWER  = 8'h49;
	localparam logic [7:0] IDX_LATENCY_SELECT   = 8'h52;
	localparam logic [7:0] IDX_INTERRUPT_CONFIG = 8'h53;
	localparam logic [7:0] IDX_TX_OUTPUT_POWER  = 8'h56;

	// Field positions
	localparam int BIT_LINK_UP      = 0;
	localparam int BIT_MODE_REVERT  = 6;
	localparam int BIT_MODE_RECONF  = 4;
	localparam int BIT_MODE_MUTE    = 3;
	localparam int BIT_MODE_NO_HOP  = 2;
	localparam int BIT_IRQ_POLARITY = 7;
	localparam int BIT_POOR_QUALITY = 5;
	localparam int BIT_LINK_ERROR   = 2;
	localparam logic [7:0] MODE_WRITABLE  = 8'h5c;
	localparam logic [7:0] CONFIG_WRITABLE = 8'hfe;
	localparam logic [7:0] FLAG_MASK      = 8'h24;

	// Values after reset and, all but RST_QUALITY, after a revert
	localparam logic [7:0] RST_LINK_ACTION_MODE = 8'h00;
	localparam logic [7:0] RST_QUALITY_WARN_TH  = 8'h00;
	localparam logic [7:0] RST_LOSS_ERROR_TH    = 8'hff;
	localparam logic [7:0] RST_RX_OUTPUT_POWER  = 8'h03;
	localparam logic [7:0] RST_TX_OUTPUT_POWER  = 8'h03;
	localparam logic [7:0] RST_LATENCY_SELECT   = 8'h02;
	localparam logic [7:0] RST_INTERRUPT_CONFIG = 8'h00;
	localparam logic [7:0] RST_QUALITY          = 8'hff;

	// Measurement windows and packets per frame
	localparam logic [5:0] QUALITY_WINDOW_FRAMES = 6'd14;
	localparam logic [5:0] LOSS_WINDOW_FRAMES    = 6'd32;
	localparam logic [3:0] PPF_HIGH_RATE = 4'd8;
	localparam logic [3:0] PPF_MID_RATE  = 4'd4;
	localparam logic [3:0] PPF_LOW_RATE  = 4'd2;
	localparam logic [1:0] RATE_48_32K = 2'h0;
	localparam logic [1:0] RATE_24_16K = 2'h1;
	localparam logic [1:0] RATE_12_8K  = 2'h2;

	// Latency codes and audio delay at 48 kSPS in microseconds
	localparam logic [7:0]  LAT_SHORT     = 8'h00;
	localparam logic [7:0]  LAT_NOMINAL   = 8'h02;
	localparam logic [7:0]  LAT_HIGH      = 8'h04;
	localparam logic [15:0] LAT_SHORT_US   = 16'd6000;
	localparam logic [15:0] LAT_NOMINAL_US = 16'd11400;
	localparam logic [15:0] LAT_HIGH_US    = 16'd16700;

	// Power code to output level in dBm
	localparam logic signed [7:0] PWR_DBM_0 = -8'sd20;
	localparam logic signed [7:0] PWR_DBM_1 = -8'sd10;
	localparam logic signed [7:0] PWR_DBM_2 = -8'sd5;
	localparam logic signed [7:0] PWR_DBM_3 = 8'sd0;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- src/rlqm_monitor.sv ----
/*
 * Link quality monitor and link configuration register bank, AXI4-Lite slave.
 * Assumes the link engine drives the packet and frame strobes on CLK, one
 * cycle each, and that the strap and rate inputs are steady on CLK.
 */
`timescale 1ns/100ps

module rlqm_monitor #(
	parameter int ADDR_W = 9
) (
	// Clock and reset
	input  wire logic              CLK,
	input  wire logic              RESET_N,
	// AXI4-Lite write address, data and response
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	input  wire logic              WVALID,
	output logic                   WREADY,
	output logic [1:0]             BRESP,
	output logic                   BVALID,
	input  wire logic              BREADY,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] ARADDR,
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	output logic [31:0]            RDATA,
	output logic [1:0]             RRESP,
	output logic                   RVALID,
	input  wire logic              RREADY,
	// Link engine events and status
	input  wire logic              IS_TX_END,
	input  wire logic [1:0]        RATE_CODE,
	input  wire logic              FRAME_END,
	input  wire logic              PKT_SLOT,
	input  wire logic              AUDIO_NEED,
	input  wire logic              PKT_HAVE,
	input  wire logic              LINK_UP,
	input  wire logic              LINK_INIT,
	input  wire logic              PEER_FOUND,
	// Link control outputs
	output logic                   MUTE,
	output logic                   HOP_OFF,
	output logic                   FORCE_RECONF,
	output logic                   REVERT_DEFAULTS,
	output logic [7:0]             LATENCY_CODE,
	output logic [15:0]            LATENCY_US48,
	output logic [1:0]             TX_POWER_CODE,
	output logic [1:0]             RX_POWER_CODE,
	output logic signed [7:0]      TX_POWER_DBM,
	output logic signed [7:0]      RX_POWER_DBM,
	output logic                   IRQ
);
	import rlqm_pkg::*;

	// Bus handshake state
	logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic        aw_have_q, w_have_q;
	logic [7:0]  aw_idx_q, wdata_q;
	logic        wstrb0_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;
	// Registers
	logic [7:0]  mode_q, wth_q, eth_q, receiver_output_power_q, transmitter_output_power_q, lat_q, cfg_q, flags_q;
	logic [7:0]  quality_q, loss_q;
	logic        link_up_q;
	// Measurement state
	logic [5:0]  qframes_q, eframes_q;
	logic [8:0]  slot_cnt_q;
	logic [7:0]  dead_cnt_q;
	// Output flops
	logic        mute_q, hop_off_q, reconf_q, revert_q, irq_q;
	logic [15:0] lat_us_q;
	logic signed [7:0] txdbm_q, rxdbm_q;

	// Write path decode
	wire        aw_take = AWVALID & awready_q;
	wire        w_take  = WVALID & wready_q;
	wire        wr_do   = aw_have_q & w_have_q & ~bvalid_q;
	wire        b_done  = bvalid_q & BREADY;
	wire        wr_en   = wr_do & wstrb0_q;
	wire [7:0]  aw_idx  = 8'(AWADDR[ADDR_W-1:2]);
	// Receiver power stays writable at either end; only transmitter power is gated
	wire        wr_tx_ok = IS_TX_END;
	wire        hit_flags = (aw_idx_q == IDX_INTERRUPT_FLAGS);
	wire        hit_state = (aw_idx_q == IDX_LINK_STATE);
	wire        hit_qual  = (aw_idx_q == IDX_LINK_QUALITY);
	wire        hit_loss  = (aw_idx_q == IDX_PERMANENT_LOSS);
	wire        hit_mode  = (aw_idx_q == IDX_LINK_ACTION_MODE);
	wire        hit_wth   = (aw_idx_q == IDX_QUALITY_WARN_TH);
	wire        hit_eth   = (aw_idx_q == IDX_LOSS_ERROR_TH);
	wire        hit_receiver_output_power = (aw_idx_q == IDX_RX_OUTPUT_POWER);
	wire        hit_transmitter_output_power = (aw_idx_q == IDX_TX_OUTPUT_POWER) & wr_tx_ok;
	wire        hit_lat   = (aw_idx_q == IDX_LATENCY_SELECT);
	wire        hit_cfg   = (aw_idx_q == IDX_INTERRUPT_CONFIG);
	wire        wr_mapped = hit_flags | hit_state | hit_qual | hit_loss | hit_mode | hit_wth | hit_eth |
	                        hit_receiver_output_power | hit_transmitter_output_power | hit_lat | hit_cfg;

	// Read path decode
	wire        ar_take = ARVALID & arready_q;
	wire        r_done  = rvalid_q & RREADY;
	wire [7:0]  ar_idx  = 8'(ARADDR[ADDR_W-1:2]);
	logic [7:0] rd_val;
	logic       rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		case (ar_idx)
			IDX_INTERRUPT_FLAGS:  rd_val = flags_q;
			IDX_LINK_STATE:       rd_val = {7'h00, link_up_q};
			IDX_LINK_QUALITY:     rd_val = IS_TX_END ? quality_q : 8'h00;
			IDX_PERMANENT_LOSS:   rd_val = loss_q;
			IDX_LINK_ACTION_MODE: rd_val = mode_q;
			IDX_QUALITY_WARN_TH:  rd_val = wth_q;
			IDX_LOSS_ERROR_TH:    rd_val = eth_q;
			IDX_RX_OUTPUT_POWER:  rd_val = receiver_output_power_q;
			IDX_TX_OUTPUT_POWER:  rd_val = transmitter_output_power_q;
			IDX_LATENCY_SELECT:   rd_val = lat_q;
			IDX_INTERRUPT_CONFIG: rd_val = cfg_q;
			default: begin
				rd_val = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Bus channel flops; one write and one read under way at a time
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_idx_q  <= 8'h00;
			wdata_q   <= 8'h00;
			wstrb0_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			awready_q <= aw_take ? 1'b0 : (b_done ? 1'b1 : awready_q);
			wready_q  <= w_take ? 1'b0 : (b_done ? 1'b1 : wready_q);
			aw_have_q <= aw_take ? 1'b1 : (wr_do ? 1'b0 : aw_have_q);
			w_have_q  <= w_take ? 1'b1 : (wr_do ? 1'b0 : w_have_q);
			if (aw_take)
				aw_idx_q <= aw_idx;
			if (w_take) begin
				wdata_q  <= WDATA[7:0];
				wstrb0_q <= WSTRB[0];
			end
			bvalid_q <= wr_do ? 1'b1 : (b_done ? 1'b0 : bvalid_q);
			if (wr_do)
				bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OKAY;
		end else begin
			arready_q <= ar_take ? 1'b0 : (r_done ? 1'b1 : arready_q);
			rvalid_q  <= ar_take ? 1'b1 : (r_done ? 1'b0 : rvalid_q);
			if (ar_take) begin
				rdata_q <= {24'h00_0000, rd_val};
				rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Packets per frame from the audio rate
	logic [3:0] ppf;
	always_comb begin
		case (RATE_CODE)
			RATE_48_32K: ppf = PPF_HIGH_RATE;
			RATE_24_16K: ppf = PPF_MID_RATE;
			RATE_12_8K:  ppf = PPF_LOW_RATE;
			default:     ppf = PPF_LOW_RATE;
		endcase
	end

	// Quality window: every slot counts, lost is what exceeds the nominal count
	wire        q_end     = FRAME_END & (qframes_q == QUALITY_WINDOW_FRAMES - 6'd1);
	wire [8:0]  slot_nx   = (slot_cnt_q == 9'h1ff) ? slot_cnt_q : slot_cnt_q + 9'(PKT_SLOT);
	wire [8:0]  nominal   = 9'(QUALITY_WINDOW_FRAMES) * 9'(ppf);
	wire [8:0]  lost_raw  = (slot_nx > nominal) ? slot_nx - nominal : 9'h000;
	wire [7:0]  lost_sat  = (lost_raw > 9'h0ff) ? 8'hff : lost_raw[7:0];
	wire [7:0]  quality_d = 8'hff - lost_sat;

	// Loss window: a packet missing when audio needs it is gone for good
	wire        dead_ev   = AUDIO_NEED & ~PKT_HAVE;
	wire        e_end     = FRAME_END & (eframes_q == LOSS_WINDOW_FRAMES - 6'd1);
	wire [7:0]  dead_nx   = (dead_cnt_q == 8'hff) ? dead_cnt_q : dead_cnt_q + 8'(dead_ev);

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			qframes_q  <= 6'd0;
			eframes_q  <= 6'd0;
			slot_cnt_q <= 9'h000;
			dead_cnt_q <= 8'h00;
			quality_q  <= RST_QUALITY;
			loss_q     <= 8'h00;
			link_up_q  <= 1'b0;
		end else begin
			qframes_q  <= q_end ? 6'd0 : qframes_q + 6'(FRAME_END);
			eframes_q  <= e_end ? 6'd0 : eframes_q + 6'(FRAME_END);
			slot_cnt_q <= q_end ? 9'h000 : slot_nx;
			dead_cnt_q <= e_end ? 8'h00 : dead_nx;
			if (q_end)
				quality_q <= quality_d;
			if (e_end)
				loss_q <= dead_nx;
			link_up_q  <= LINK_UP;
		end
	end

	// Threshold conditions; poor quality exists only at the transmitter end
	wire poor_cond  = IS_TX_END & (quality_q <= wth_q);
	wire error_cond = (loss_q >= eth_q);
	wire do_revert  = LINK_INIT & ~PEER_FOUND & mode_q[BIT_MODE_REVERT];
	wire [7:0] flag_set = {2'b00, poor_cond, 2'b00, error_cond, 2'b00};
	wire [7:0] flag_clr = (wr_en & hit_flags) ? (wdata_q & FLAG_MASK) : 8'h00;

	// Software registers; a revert reloads the stored defaults
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mode_q  <= RST_LINK_ACTION_MODE;
			wth_q   <= RST_QUALITY_WARN_TH;
			eth_q   <= RST_LOSS_ERROR_TH;
			receiver_output_power_q <= RST_RX_OUTPUT_POWER;
			transmitter_output_power_q <= RST_TX_OUTPUT_POWER;
			lat_q   <= RST_LATENCY_SELECT;
			cfg_q   <= RST_INTERRUPT_CONFIG;
		end else if (do_revert) begin
			mode_q  <= RST_LINK_ACTION_MODE;
			wth_q   <= RST_QUALITY_WARN_TH;
			eth_q   <= RST_LOSS_ERROR_TH;
			receiver_output_power_q <= RST_RX_OUTPUT_POWER;
			transmitter_output_power_q <= RST_TX_OUTPUT_POWER;
			lat_q   <= RST_LATENCY_SELECT;
			cfg_q   <= RST_INTERRUPT_CONFIG;
		end else begin
			// Reconfigure bit acts once and never stays set
			if (wr_en & hit_mode)
				mode_q <= wdata_q & MODE_WRITABLE & ~(8'h01 << BIT_MODE_RECONF);
			if (wr_en & hit_wth)
				wth_q <= wdata_q;
			if (wr_en & hit_eth)
				eth_q <= wdata_q;
			if (wr_en & hit_receiver_output_power)
				receiver_output_power_q <= {6'h00, wdata_q[1:0]};
			if (wr_en & hit_transmitter_output_power)
				transmitter_output_power_q <= {6'h00, wdata_q[1:0]};
			if (wr_en & hit_lat)
				lat_q <= wdata_q;
			if (wr_en & hit_cfg)
				cfg_q <= wdata_q & CONFIG_WRITABLE;
		end
	end

	// Flags: a new event in the clearing cycle keeps the flag set
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			flags_q <= 8'h00;
		else
			flags_q <= (flags_q & ~flag_clr) | flag_set;
	end

	// Power code to level
	function automatic logic signed [7:0] pwr_dbm(input logic [1:0] code);
		case (code)
			2'd0:    pwr_dbm = PWR_DBM_0;
			2'd1:    pwr_dbm = PWR_DBM_1;
			2'd2:    pwr_dbm = PWR_DBM_2;
			default: pwr_dbm = PWR_DBM_3;
		endcase
	endfunction

	// Latency code to nominal delay at 48 kSPS; odd codes fall to the lower setting
	logic [15:0] lat_us;
	always_comb begin
		if (lat_q >= LAT_HIGH)
			lat_us = LAT_HIGH_US;
		else if (lat_q >= LAT_NOMINAL)
			lat_us = LAT_NOMINAL_US;
		else
			lat_us = LAT_SHORT_US;
	end

	wire [7:0] irq_en   = flags_q & cfg_q & FLAG_MASK;
	wire       irq_act  = |irq_en;
	wire       irq_lvl  = irq_act ~^ cfg_q[BIT_IRQ_POLARITY];

	// Output flops
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mute_q    <= 1'b0;
			hop_off_q <= 1'b0;
			reconf_q  <= 1'b0;
			revert_q  <= 1'b0;
			irq_q     <= 1'b1;
			lat_us_q  <= LAT_NOMINAL_US;
			txdbm_q   <= PWR_DBM_3;
			rxdbm_q   <= PWR_DBM_3;
		end else begin
			mute_q    <= mode_q[BIT_MODE_MUTE] & (loss_q > eth_q);
			hop_off_q <= mode_q[BIT_MODE_NO_HOP];
			reconf_q  <= wr_en & hit_mode & wdata_q[BIT_MODE_RECONF];
			revert_q  <= do_revert;
			irq_q     <= irq_lvl;
			lat_us_q  <= lat_us;
			txdbm_q   <= pwr_dbm(transmitter_output_power_q[1:0]);
			rxdbm_q   <= pwr_dbm(receiver_output_power_q[1:0]);
		end
	end

	assign AWREADY         = awready_q;
	assign WREADY          = wready_q;
	assign BVALID          = bvalid_q;
	assign BRESP           = bresp_q;
	assign ARREADY         = arready_q;
	assign RVALID          = rvalid_q;
	assign RDATA           = rdata_q;
	assign RRESP           = rresp_q;
	assign MUTE            = mute_q;
	assign HOP_OFF         = hop_off_q;
	assign FORCE_RECONF    = reconf_q;
	assign REVERT_DEFAULTS = revert_q;
	assign LATENCY_CODE    = lat_q;
	assign LATENCY_US48    = lat_us_q;
	assign TX_POWER_CODE   = transmitter_output_power_q[1:0];
	assign RX_POWER_CODE   = receiver_output_power_q[1:0];
	assign TX_POWER_DBM    = txdbm_q;
	assign RX_POWER_DBM    = rxdbm_q;
	assign IRQ             = irq_q;

	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	a_quality_window_update: assert property (q_end |=> quality_q == $past(quality_d))
		else $error("quality not loaded at window end");
	a_nominal_count: assert property (RATE_CODE == RATE_48_32K |-> nominal == 9'd112)
		else $error("nominal packet count wrong");
	a_loss_window: assert property (e_end |=> loss_q == $past(dead_nx) && dead_cnt_q == 8'h00)
		else $error("loss count not loaded at window end");
	a_dead_counted: assert property (dead_ev && !e_end && dead_cnt_q < 8'hff |=> dead_cnt_q == $past(dead_cnt_q) + 8'h01)
		else $error("permanent loss not counted");
	a_poor_flag: assert property (IS_TX_END && quality_q <= wth_q |=> flags_q[BIT_POOR_QUALITY])
		else $error("poor quality flag not set");
	a_error_flag: assert property (loss_q >= eth_q |=> flags_q[BIT_LINK_ERROR])
		else $error("link error flag not set");
	a_rx_no_quality: assert property (!IS_TX_END |=> !$rose(flags_q[BIT_POOR_QUALITY]))
		else $error("poor quality raised at receiver end");
	a_revert_regs: assert property (do_revert |=> mode_q == RST_LINK_ACTION_MODE && REVERT_DEFAULTS)
		else $error("revert did not reload defaults");
	a_reconf_pulse: assert property (FORCE_RECONF |=> !FORCE_RECONF)
		else $error("reconfigure pulse longer than one cycle");
	a_mute_follow: assert property (mode_q[BIT_MODE_MUTE] && loss_q > eth_q ##1 mode_q[BIT_MODE_MUTE] |-> MUTE)
		else $error("mute missing while losses exceed threshold");
	a_irq_polarity: assert property (##1 IRQ == ($past(irq_act) ~^ $past(cfg_q[BIT_IRQ_POLARITY])))
		else $error("interrupt pin level wrong");
	a_flag_clear: assert property (wr_en && hit_flags && wdata_q[BIT_LINK_ERROR] && !error_cond |=> !flags_q[BIT_LINK_ERROR])
		else $error("link error flag not cleared");
	a_write_answer: assert property (wr_do |=> BVALID)
		else $error("write not answered");

	c_quality_drop: cover property (q_end && quality_d < 8'hff);
	c_irq_raise:    cover property (irq_act ##1 IRQ == cfg_q[BIT_IRQ_POLARITY]);
	c_revert:       cover property (do_revert);
	c_mute:         cover property ($rose(MUTE));

endmodule

// ---- dv/rlqm_link_model.sv ----
/* Link engine model: frames of packet slots and audio needs.
   Assumes the bench calls run only while reset is released. */
`timescale 1ns/100ps
module rlqm_link_model (
	// Clock
	input  wire logic CLK,
	// Link events
	output logic      FRAME_END,
	output logic      PKT_SLOT,
	output logic      AUDIO_NEED,
	output logic      PKT_HAVE
);
	initial begin
		FRAME_END = 1'b0;
		PKT_SLOT = 1'b0;
		AUDIO_NEED = 1'b0;
		PKT_HAVE = 1'b0;
	end
	// Frame 0 carries the retries and the misses
	task automatic run(input int f, input int s, input int x, input int m);
		for (int i = 0; i < f; i++) begin
			for (int j = 0; j < s + (i == 0 ? x : 0); j++) begin
				@(posedge CLK);
				PKT_SLOT <= 1'b1;
				AUDIO_NEED <= 1'b1;
				PKT_HAVE <= !(i == 0 && j < m);
			end
			@(posedge CLK);
			PKT_SLOT <= 1'b0;
			AUDIO_NEED <= 1'b0;
			// Not sampled here, so it must not look held
			PKT_HAVE <= !PKT_HAVE;
			FRAME_END <= 1'b1;
			@(posedge CLK);
			FRAME_END <= 1'b0;
		end
	endtask
endmodule

// ---- dv/rlqm_monitor_tb.sv ----
/* Self-checking bench: AXI4-Lite master tasks, link model, one task per scenario.
   Assumes the package and the monitor are compiled first. */
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, s); end end
module rf_link_quality_monitor_tb_top;
	import rlqm_pkg::*;
	logic CLK = 1'b0, RESET_N = 1'b0, IS_TX_END = 1'b1, LINK_UP = 1'b0, LINK_INIT = 1'b0, PEER_FOUND = 1'b1;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic [8:0] AWADDR = 9'h000, ARADDR = 9'h000;
	logic [31:0] WDATA = 32'h0, RDATA, rdv;
	logic [3:0] WSTRB = 4'hf;
	logic [1:0] RATE_CODE = 2'h0, BRESP, RRESP, TX_POWER_CODE, RX_POWER_CODE;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, MUTE, HOP_OFF, FORCE_RECONF, REVERT_DEFAULTS, IRQ;
	logic FRAME_END, PKT_SLOT, AUDIO_NEED, PKT_HAVE;
	logic [7:0] LATENCY_CODE;
	logic [15:0] LATENCY_US48;
	logic signed [7:0] TX_POWER_DBM, RX_POWER_DBM;
	int failures = 0, total_checks = 0, n_reconf = 0, n_revert = 0;
	rlqm_monitor rlqm_monitor_inst (.*);
	rlqm_link_model rlqm_link_model_inst (.*);
	initial forever #2.5 CLK = ~CLK;
	// Pulses are counted so no check depends on catching one exact cycle
	always @(posedge CLK) begin
		n_reconf <= n_reconf + int'(FORCE_RECONF === 1'b1);
		n_revert <= n_revert + int'(REVERT_DEFAULTS === 1'b1);
	end
	task automatic end_of_test;
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge CLK);
		@(negedge CLK);
	endtask
	task automatic rst;
		@(posedge CLK);
		RESET_N <= 1'b0;
		repeat (16) @(posedge CLK);
		RESET_N <= 1'b1;
		@(posedge CLK);
	endtask
	// Handshakes are judged at the falling edge, where the next rising edge's inputs are settled
	task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic a, w, r, dn;
		logic [1:0] rs;
		dn = 1'b0;
		@(posedge CLK);
		AWADDR <= {idx[6:0], 2'b00};
		ARADDR <= {idx[6:0], 2'b00};
		WDATA <= {24'h0, d};
		AWVALID <= we;
		WVALID <= we;
		BREADY <= we;
		ARVALID <= !we;
		RREADY <= !we;
		for (int i = 0; i < 40 && dn !== 1'b1; i++) begin
			@(negedge CLK);
			a = AWVALID & AWREADY;
			w = WVALID & WREADY;
			r = ARVALID & ARREADY;
			dn = (BVALID & BREADY) | (RVALID & RREADY);
			rs = we ? BRESP : RRESP;
			rdv = RDATA;
			@(posedge CLK);
			AWVALID <= AWVALID & !a;
			WVALID <= WVALID & !w;
			ARVALID <= ARVALID & !r;
			BREADY <= BREADY & !dn;
			RREADY <= RREADY & !dn;
		end
		if (dn !== 1'b1) begin
			failures++;
			end_of_test;
		end
		`CHK("resp", er, rs)
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, RESP_OKAY);
	endtask
	task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00, RESP_OKAY);
		`CHK(nm, {24'h0, e}, rdv)
	endtask
	task automatic t_reset;
		logic [7:0] ix [7] = '{IDX_LINK_ACTION_MODE, IDX_QUALITY_WARN_TH, IDX_LOSS_ERROR_TH,
			IDX_RX_OUTPUT_POWER, IDX_TX_OUTPUT_POWER, IDX_LATENCY_SELECT, IDX_LINK_QUALITY};
		logic [7:0] ev [7] = '{8'h00, 8'h00, 8'hff, 8'h03, 8'h03, 8'h02, 8'hff};
		foreach (ix[i]) rd("reset value", ix[i], ev[i]);
		`CHK("irq idle", 1'b1, IRQ)
		`CHK("hop idle", 1'b0, HOP_OFF)
	endtask
	task automatic t_bus;
		bus(1'b0, 8'h60, 8'h00, RESP_SLVERR);
		`CHK("unmapped data", 32'h0, rdv)
		bus(1'b1, 8'h60, 8'h55, RESP_SLVERR);
		wr(IDX_LINK_QUALITY, 8'h00);
		rd("quality ro", IDX_LINK_QUALITY, 8'hff);
		WSTRB <= 4'he;
		wr(IDX_QUALITY_WARN_TH, 8'h55);
		WSTRB <= 4'hf;
		rd("strobe off", IDX_QUALITY_WARN_TH, 8'h00);
		LINK_UP <= 1'b1;
		rd("link up", IDX_LINK_STATE, 8'h01);
		LINK_UP <= 1'b0;
		rd("link down", IDX_LINK_STATE, 8'h00);
	endtask
	task automatic t_codes;
		logic [15:0] us [3] = '{16'h1770, 16'h2c88, 16'h413c};
		logic [7:0] db [4] = '{8'hec, 8'hf6, 8'hfb, 8'h00};
		for (int i = 0; i < 3; i++) begin
			wr(IDX_LATENCY_SELECT, 8'(2 * i));
			idle(2);
			`CHK("latency code", 8'(2 * i), LATENCY_CODE)
			`CHK("latency us", us[i], LATENCY_US48)
		end
		for (int i = 0; i < 4; i++) begin
			wr(IDX_TX_OUTPUT_POWER, 8'(i));
			wr(IDX_RX_OUTPUT_POWER, 8'(3 - i));
			idle(2);
			`CHK("tx dbm", db[i], TX_POWER_DBM)
			`CHK("rx dbm", db[3 - i], RX_POWER_DBM)
			`CHK("tx code", 2'(i), TX_POWER_CODE)
			`CHK("rx code", 2'(3 - i), RX_POWER_CODE)
		end
	endtask
	task automatic t_mode;
		wr(IDX_LINK_ACTION_MODE, 8'h5c);
		idle(2);
		rd("mode bits", IDX_LINK_ACTION_MODE, 8'h4c);
		`CHK("hop off", 1'b1, HOP_OFF)
		`CHK("reconf pulses", 1, n_reconf)
	endtask
	task automatic t_rate;
		int ppf [4] = '{8, 4, 2, 2};
		for (int i = 0; i < 4; i++) begin
			rst;
			RATE_CODE <= 2'(i);
			rlqm_link_model_inst.run(14, ppf[i], 5, 0);
			idle(2);
			rd("quality by rate", IDX_LINK_QUALITY, 8'hfa);
		end
	endtask
	task automatic t_flags;
		RATE_CODE <= 2'h0;
		rst;
		wr(IDX_INTERRUPT_CONFIG, 8'ha4);
		wr(IDX_QUALITY_WARN_TH, 8'hfc);
		wr(IDX_LOSS_ERROR_TH, 8'h01);
		wr(IDX_LINK_ACTION_MODE, 8'h08);
		idle(2);
		`CHK("irq off high", 1'b0, IRQ)
		rlqm_link_model_inst.run(14, 8, 3, 0);
		idle(2);
		rd("quality", IDX_LINK_QUALITY, 8'hfc);
		rd("poor flag", IDX_INTERRUPT_FLAGS, 8'h20);
		`CHK("irq poor", 1'b1, IRQ)
		wr(IDX_INTERRUPT_FLAGS, 8'h20);
		rd("set wins", IDX_INTERRUPT_FLAGS, 8'h20);
		wr(IDX_QUALITY_WARN_TH, 8'h00);
		wr(IDX_INTERRUPT_FLAGS, 8'h20);
		idle(2);
		`CHK("irq clear", 1'b0, IRQ)
		rlqm_link_model_inst.run(18, 8, 0, 2);
		idle(2);
		rd("loss", IDX_PERMANENT_LOSS, 8'h02);
		rd("error flag", IDX_INTERRUPT_FLAGS, 8'h04);
		`CHK("irq error", 1'b1, IRQ)
		`CHK("mute", 1'b1, MUTE)
		wr(IDX_LOSS_ERROR_TH, 8'h02);
		idle(2);
		`CHK("no mute at equal", 1'b0, MUTE)
		wr(IDX_INTERRUPT_FLAGS, 8'h04);
		rd("flag at equal", IDX_INTERRUPT_FLAGS, 8'h04);
		wr(IDX_INTERRUPT_CONFIG, 8'h20);
		idle(2);
		`CHK("irq error masked", 1'b1, IRQ)
		wr(IDX_INTERRUPT_CONFIG, 8'h04);
		idle(2);
		`CHK("irq active low", 1'b0, IRQ)
	endtask
	task automatic t_rx_end;
		IS_TX_END <= 1'b0;
		rd("rx quality", IDX_LINK_QUALITY, 8'h00);
		rd("rx loss", IDX_PERMANENT_LOSS, 8'h02);
		bus(1'b1, IDX_TX_OUTPUT_POWER, 8'h00, RESP_SLVERR);
		rd("rx tx power", IDX_TX_OUTPUT_POWER, 8'h03);
		IS_TX_END <= 1'b1;
	endtask
	// A found peer must not revert; only the second init may
	task automatic t_revert;
		wr(IDX_LINK_ACTION_MODE, 8'h40);
		for (int i = 1; i >= 0; i--) begin
			@(posedge CLK);
			LINK_INIT <= 1'b1;
			PEER_FOUND <= 1'(i);
			@(posedge CLK);
			LINK_INIT <= 1'b0;
		end
		idle(2);
		`CHK("revert pulses", 1, n_revert)
		rd("err thr reverted", IDX_LOSS_ERROR_TH, 8'hff);
		rd("mode reverted", IDX_LINK_ACTION_MODE, 8'h00);
	endtask
	initial begin
		rst;
		t_reset;
		t_bus;
		t_codes;
		t_mode;
		t_rate;
		t_flags;
		t_rx_end;
		t_revert;
		end_of_test;
	end
endmodule
